// >>> verilog/toff_monitor.sv
// Dual channel torque off request logic with discrepancy check
`timescale 1ns/10ps
`include "toff_map.svh"
//
// Summary of operation
// RULE_01: Request only when both inputs low.
// RULE_02: Only the two inputs request torque off.
// RULE_03: Feedback contact closed while torque off active.
// RULE_04: Active if both low within discrepancy time.
// RULE_05: Error when inputs differ beyond discrepancy time.
// RULE_06: Discrepancy time defaults to 100 ms.
// RULE_07: Brief low test pulses never trigger.
// RULE_08: Test pulses up to 3.5 ms tolerated.
// RULE_09: Driver supply off while torque off active.
// RULE_10: No standstill monitoring in torque off.
// RULE_11: No cross-circuit detection on input wiring.
// RULE_12: External circuit should switch both together.
// RULE_13: Sample channels and run machine every 10 ms.
// RULE_14: Power stage disabled within 125 us.
// RULE_15: Indicator green inactive, yellow active, matches contact.
// RULE_16: Synchronise inputs; error latched until acknowledged.

module toff_monitor
  import toff_pkg::*;
#(
  // Clock cycles per evaluation tick
  parameter int TICK_CYCLES  = (`TOFF_CLK_HZ / 1000) * `TOFF_TICK_MS,
  // Longest tolerated test pulse in clock cycles
  parameter int PULSE_CYCLES = (`TOFF_CLK_HZ / 1000000) * `TOFF_TEST_PULSE_US,
  // Discrepancy time in evaluation ticks
  parameter int DISC_TICKS   = `TOFF_DISC_MS / `TOFF_TICK_MS
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Control inputs, high means no request from that channel
  input  wire logic        torque_off_request_a,
  input  wire logic        torque_off_request_b,
  // Error acknowledge, one-cycle pulse
  input  wire logic        error_ack,
  // Driver supply to the power semiconductors, per channel
  output toff_pkg::toff_pair_t driver_supply,
  // Power stage switching activation allowed
  output logic             pwm_enable,
  // Feedback contact drive, high closes the contact
  output logic             feedback_contact_closed,
  // Status indicator
  output logic             led_green,
  output logic             led_yellow,
  // Torque off state and latched discrepancy error
  output logic             torque_off_active,
  output logic             discrepancy_error
);
  import toff_pkg::*;

  // Cycles allowed between supply loss and power stage switch-off
  localparam int PWM_OFF_CYCLES = (`TOFF_CLK_HZ / 1000000) * `TOFF_PWM_OFF_US;
  localparam int TW = $clog2(TICK_CYCLES);
  localparam int DW = $clog2(DISC_TICKS + 1);

  // Refuse values the logic cannot serve
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end
  if (PULSE_CYCLES < 1) begin : g_bad_pulse
    $error("PULSE_CYCLES must be at least 1");
  end
  if (DISC_TICKS < 1) begin : g_bad_disc
    $error("DISC_TICKS must be at least 1");
  end
  if (`TOFF_PWM_LATENCY > PWM_OFF_CYCLES) begin : g_bad_pwm
    $error("Power stage switch-off path too slow");
  end

  toff_pair_t    level;            // Filtered channel levels
  toff_pair_t    supply_reg;       // Driver supply per channel
  toff_pair_t    supply_next;
  logic          pwm_reg;          // Power stage activation
  logic          pwm_next;
  logic [TW-1:0] tick_cnt_reg;     // Divider for the evaluation tick
  logic [TW-1:0] tick_cnt_next;
  logic          tick_reg;         // One-cycle tick pulse
  logic          tick_next;
  toff_state_t   state_reg;        // Discrepancy state
  toff_state_t   state_next;
  logic [DW-1:0] disc_cnt_reg;     // Ticks spent with unequal channels
  logic [DW-1:0] disc_cnt_next;
  logic          err_reg;          // Latched discrepancy error
  logic          err_next;
  logic          err_set;          // Error event of this cycle
  logic          active_reg;       // Torque off active
  logic          active_next;
  logic          contact_reg;      // Feedback contact drive
  logic          green_reg;        // Indicator green
  logic          yellow_reg;       // Indicator yellow

  // RULE_02: only the two inputs feed the torque off state
  toff_chan_filter #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_filt_a (
    .clock     (clock),
    .rst       (rst),
    .raw_in    (torque_off_request_a),
    .level_out (level.a)
  );

  toff_chan_filter #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_filt_b (
    .clock     (clock),
    .rst       (rst),
    .raw_in    (torque_off_request_b),
    .level_out (level.b)
  );

  // Supply and power stage path runs every cycle, not on the slow tick,
  // so a supply loss reaches the power stage within two clocks.
  always_comb begin
    // RULE_09: channel low cuts its supply
    supply_next = level;
    // RULE_14: stage off next cycle
    pwm_next    = supply_reg.a & supply_reg.b & ~err_reg;
  end

  // Supply and power stage flops, both off from reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      supply_reg <= '0;
      pwm_reg    <= 1'b0;
    end else begin
      supply_reg <= supply_next;
      pwm_reg    <= pwm_next;
    end
  end

  // Evaluation tick divider
  always_comb begin
    tick_cnt_next = tick_cnt_reg + TW'(1);
    tick_next     = 1'b0;
    // RULE_13: one tick per 10 ms
    if (tick_cnt_reg == TW'(TICK_CYCLES - 1)) begin
      tick_cnt_next = '0;
      tick_next     = 1'b1;
    end
  end

  // Tick flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg     <= tick_next;
    end
  end

  // Discrepancy state machine, moves only on a tick. Standstill is not
  // watched and the wiring is not checked for cross faults; an external
  // safety relay must add that if the application needs it.
  // RULE_10: no standstill monitor
  // RULE_11: no cross-circuit check
  always_comb begin
    state_next    = state_reg;
    disc_cnt_next = disc_cnt_reg;
    active_next   = active_reg;
    err_set       = 1'b0;
    if (tick_reg) begin
      // RULE_13: judge supplies each tick
      // RULE_01: both low means request
      // RULE_04: active once both are low
      active_next = ~supply_reg.a & ~supply_reg.b;
      case (state_reg)
        TOFF_ST_EQUAL: begin
          // A level change leaves the channels unequal
          if (supply_reg.a != supply_reg.b) begin
            state_next    = TOFF_ST_DISC;
            disc_cnt_next = '0;
          end
        end
        TOFF_ST_DISC: begin
          if (supply_reg.a == supply_reg.b) begin
            // Second channel followed in time
            state_next = TOFF_ST_EQUAL;
          end else if (disc_cnt_reg == DW'(DISC_TICKS)) begin
            // RULE_05: unequal too long
            // RULE_06: default 100 ms
            state_next = TOFF_ST_FAULT;
            err_set    = 1'b1;
          end else begin
            disc_cnt_next = disc_cnt_reg + DW'(1);
          end
        end
        TOFF_ST_FAULT: begin
          // Error stays latched; the machine rearms once equal again
          if (supply_reg.a == supply_reg.b) begin
            state_next = TOFF_ST_EQUAL;
          end
        end
        default: begin
          state_next = TOFF_ST_EQUAL;
        end
      endcase
    end
  end

  // RULE_16: error held until acknowledged, set wins
  always_comb begin
    err_next = err_reg;
    if (error_ack) begin
      err_next = 1'b0;
    end
    if (err_set) begin
      err_next = 1'b1;
    end
  end

  // State machine flops
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg    <= TOFF_ST_EQUAL;
      disc_cnt_reg <= '0;
      active_reg   <= 1'b0;
      err_reg      <= 1'b0;
    end else begin
      state_reg    <= state_next;
      disc_cnt_reg <= disc_cnt_next;
      active_reg   <= active_next;
      err_reg      <= err_next;
    end
  end

  // Contact and indicator follow the active flag one clock later. Both
  // stay dark after reset until the first tick has judged the inputs.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      contact_reg <= 1'b0;
      green_reg   <= 1'b0;
      yellow_reg  <= 1'b0;
    end else if (tick_reg || state_reg != TOFF_ST_EQUAL || contact_reg != active_reg) begin
      // RULE_03: contact closed while active
      contact_reg <= active_reg;
      // RULE_15: indicator matches contact
      green_reg   <= ~active_reg;
      yellow_reg  <= active_reg;
    end
  end

  // Outputs straight from flops
  assign driver_supply           = supply_reg;
  assign pwm_enable              = pwm_reg;
  assign feedback_contact_closed = contact_reg;
  assign led_green               = green_reg;
  assign led_yellow              = yellow_reg;
  assign torque_off_active       = active_reg;
  assign discrepancy_error       = err_reg;

endmodule // toff_monitor

// >>> verilog/toff_map.svh
// Constants of the dual channel torque off monitor
`ifndef TOFF_MAP_SVH
`define TOFF_MAP_SVH

// System clock rate in hertz
`define TOFF_CLK_HZ          25000000
// Evaluation cycle of the discrepancy state machine, in milliseconds
`define TOFF_TICK_MS         10
// Default discrepancy time, in milliseconds
`define TOFF_DISC_MS         100
// Longest tolerated low-going test pulse, in microseconds
`define TOFF_TEST_PULSE_US   3500
// Latest switch-off of power stage activation after supply loss, in microseconds
`define TOFF_PWM_OFF_US      125
// Cycles from a supply channel change to the power stage enable flop
`define TOFF_PWM_LATENCY     2

`endif

// >>> verilog/toff_pkg.sv
// Types of the dual channel torque off monitor
package toff_pkg;

  // One bit per channel, A and B travel together
  typedef struct packed {
    logic a;
    logic b;
  } toff_pair_t;

  // Discrepancy state machine, one-hot
  typedef enum logic [2:0] {
    TOFF_ST_EQUAL = 3'h1,
    TOFF_ST_DISC  = 3'h2,
    TOFF_ST_FAULT = 3'h4
  } toff_state_t;

endpackage

// >>> verilog/toff_chan_filter.sv
// One control channel: synchroniser and test pulse filter
`timescale 1ns/10ps
`include "toff_map.svh"

module toff_chan_filter #(
  parameter int PULSE_CYCLES = 87500
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Raw control input, high means no request
  input  wire logic raw_in,
  // Filtered level, low after reset and after a real request
  output logic      level_out
);
  import toff_pkg::*;

  localparam int CW = $clog2(PULSE_CYCLES + 1);

  // Refuse a zero pulse limit, the counter would never arm
  if (PULSE_CYCLES < 1) begin : g_bad_pulse
    $error("PULSE_CYCLES must be at least 1");
  end

  logic          sync1_reg;     // First synchroniser stage, read only by stage two
  logic          sync2_reg;     // Second synchroniser stage
  logic [CW-1:0] low_cnt_reg;   // Consecutive low samples
  logic [CW-1:0] low_cnt_next;
  logic          level_reg;     // Filtered channel level
  logic          level_next;

  // RULE_16: two stage synchroniser
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Low must outlast the longest test pulse before it counts
  always_comb begin
    low_cnt_next = low_cnt_reg;
    level_next   = level_reg;
    if (sync2_reg) begin
      // High restores the channel at once
      low_cnt_next = '0;
      level_next   = 1'b1;
    end else if (low_cnt_reg == CW'(PULSE_CYCLES)) begin
      // RULE_07: pulse ignored until here
      level_next   = 1'b0;
    end else begin
      // RULE_08: count up to 3.5 ms
      low_cnt_next = low_cnt_reg + CW'(1);
    end
  end

  // Reset to low: the safe reading until the input proves high
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      low_cnt_reg <= '0;
      level_reg   <= 1'b0;
    end else begin
      low_cnt_reg <= low_cnt_next;
      level_reg   <= level_next;
    end
  end

  assign level_out = level_reg;

endmodule // toff_chan_filter

// >>> test/toff_monitor_props.sv
// Port checker of the torque off monitor
`timescale 1ns/10ps
module toff_monitor_props
  import toff_pkg::*;
#(
  parameter int TICK_CYCLES  = 20,
  parameter int PULSE_CYCLES = 5,
  parameter int DISC_TICKS   = 3
) (
  // Clock, reset and inputs
  input wire logic                 clock,
  input wire logic                 rst,
  input wire logic                 torque_off_request_a,
  input wire logic                 error_ack,
  // Watched outputs
  input wire toff_pkg::toff_pair_t driver_supply,
  input wire logic                 pwm_enable,
  input wire logic                 feedback_contact_closed,
  input wire logic                 led_green,
  input wire logic                 led_yellow,
  input wire logic                 torque_off_active,
  input wire logic                 discrepancy_error
);
  logic [7:0]  run_reg, run_next;   // Clocks with input A low
  logic [31:0] diff_reg, diff_next; // Clocks with supplies unequal

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Saturating run counter, so long requests never wrap
  always_comb begin
    run_next = torque_off_request_a ? 8'h00 : run_reg + 8'(run_reg != 8'hFF);
    diff_next = (driver_supply.a == driver_supply.b) ? 32'h0 : diff_reg + 32'h1;
  end

  // Register the counters
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      run_reg  <= 8'h00;
      diff_reg <= 32'h0;
    end else begin
      run_reg  <= run_next;
      diff_reg <= diff_next;
    end
  end

  // A supply channel drops
  sequence s_supply_drop;
    $fell(driver_supply.a) || $fell(driver_supply.b);
  endsequence

  a_led_contact_match: assert property (led_yellow == feedback_contact_closed)
    else $error("yellow indicator differs from contact");
  a_led_one_colour: assert property (!(led_green && led_yellow))
    else $error("both indicator colours lit");
  a_contact_follows_state: assert property (feedback_contact_closed == $past(torque_off_active))
    else $error("contact does not follow torque off state");
  a_pwm_off_quick: assert property (s_supply_drop |-> ##1 !pwm_enable)
    else $error("power stage still enabled after supply loss");
  a_pwm_needs_supply: assert property (pwm_enable |-> $past(driver_supply) == 2'b11)
    else $error("power stage enabled without both supplies");
  a_active_both_low: assert property ($rose(torque_off_active) |-> $past(driver_supply) == 2'b00)
    else $error("torque off entered without both supplies low");
  a_error_held: assert property (discrepancy_error && !error_ack |=> discrepancy_error)
    else $error("error dropped without acknowledge");
  a_error_span: assert property ($rose(discrepancy_error) |-> $past(diff_reg) >= DISC_TICKS * TICK_CYCLES)
    else $error("error raised before discrepancy time");
  a_pulse_ignored: assert property ($fell(driver_supply.a) |-> run_reg > PULSE_CYCLES)
    else $error("short low pulse removed supply A");
  a_request_taken: assert property (run_reg == PULSE_CYCLES + 8 |-> !driver_supply.a)
    else $error("long low on A kept supply A on");
endmodule // toff_monitor_props

bind toff_monitor toff_monitor_props #(.TICK_CYCLES(TICK_CYCLES), .PULSE_CYCLES(PULSE_CYCLES),
  .DISC_TICKS(DISC_TICKS)) props_u (.clock(clock), .rst(rst),
  .torque_off_request_a(torque_off_request_a), .error_ack(error_ack),
  .driver_supply(driver_supply), .pwm_enable(pwm_enable),
  .feedback_contact_closed(feedback_contact_closed), .led_green(led_green),
  .led_yellow(led_yellow), .torque_off_active(torque_off_active),
  .discrepancy_error(discrepancy_error));

// >>> test/toff_safety_dev.sv
// Model of the external safety switching device
`timescale 1ns/10ps
module toff_safety_dev #(
  parameter int PULSE_LEN = 5
) (
  // Clock and commands from the bench
  input wire logic clock,
  input wire logic cmd_a,
  input wire logic cmd_b,
  input wire logic test_start,
  // Control outputs, high means no request
  output logic     chan_a,
  output logic     chan_b
);
  int cnt; // Remaining test pulse clocks

  // Starts low, so the drive powers up in torque off
  initial begin
    chan_a = 1'b0;
    chan_b = 1'b0;
    cnt = 0;
  end

  // Outputs change off the sampling edge
  always @(negedge clock) begin
    cnt = test_start ? PULSE_LEN : (cnt > 0 ? cnt - 1 : 0);
    // each channel follows its own command; test pulses hit both together
    chan_a <= cmd_a && cnt == 0;
    chan_b <= cmd_b && cnt == 0;
  end
endmodule // toff_safety_dev

// >>> test/toff_monitor_bench.sv
// Self-checking bench of the torque off monitor
`timescale 1ns/10ps
module toff_monitor_bench;
  import toff_pkg::*;
  localparam int TICK  = 20; // Short evaluation tick
  localparam int PULSE = 5;  // Short test pulse limit
  localparam int DISC  = 3;  // Discrepancy time in ticks
  logic       clock, rst, cmd_a, cmd_b, test_start, error_ack, req_a, req_b;
  logic       pwm, contact, green, yellow, active, error;
  toff_pair_t supply;
  logic [7:0] outs; // supply, pwm, contact, green, yellow, active, error
  int         fails, tests_run;

  assign outs = {supply, pwm, contact, green, yellow, active, error};

  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  toff_safety_dev #(.PULSE_LEN(PULSE)) dev_u (.clock(clock), .cmd_a(cmd_a), .cmd_b(cmd_b),
    .test_start(test_start), .chan_a(req_a), .chan_b(req_b));
  toff_monitor #(.TICK_CYCLES(TICK), .PULSE_CYCLES(PULSE), .DISC_TICKS(DISC)) dut_u (
    .clock(clock), .rst(rst), .torque_off_request_a(req_a), .torque_off_request_b(req_b),
    .error_ack(error_ack), .driver_supply(supply), .pwm_enable(pwm),
    .feedback_contact_closed(contact), .led_green(green), .led_yellow(yellow),
    .torque_off_active(active), .discrepancy_error(error));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic drive(input logic a, input logic b);
    cmd_a <= a;
    cmd_b <= b;
  endtask

  // Both high: supplies on, green
  task automatic t_release;
    drive(1'b1, 1'b1);
    cyc(TICK + 12);
    chk("released", 8'hE8, outs);
  endtask

  // Longest tolerated pulse on both channels
  task automatic t_test_pulse;
    test_start <= 1'b1;
    cyc(1);
    test_start <= 1'b0;
    repeat (PULSE + 12) begin
      cyc(1);
      chk("test pulse", 8'hE8, outs);
    end
  endtask

  // Both low together, then release
  task automatic t_request;
    drive(1'b0, 1'b0);
    cyc(PULSE + 8);
    chk("supply off", 8'h00, {5'h00, outs[7:5]});
    cyc(TICK + 4);
    chk("torque off", 8'h16, outs);
    drive(1'b1, 1'b1);
    cyc(TICK + 12);
    chk("released again", 8'hE8, outs);
  endtask

  // Second channel one tick late
  task automatic t_staggered;
    drive(1'b0, 1'b1);
    cyc(TICK);
    drive(1'b0, 1'b0);
    cyc(3 * TICK);
    chk("late second channel", 8'h16, outs);
    drive(1'b1, 1'b1);
    cyc(TICK + 12);
  endtask

  // One channel only: error, latch, acknowledge
  task automatic t_discrepancy;
    drive(1'b0, 1'b1);
    cyc(2 * TICK);
    chk("within discrepancy", 8'h48, outs);
    cyc(5 * TICK);
    chk("discrepancy error", 8'h49, outs);
    drive(1'b1, 1'b1);
    cyc(3 * TICK);
    chk("error held", 8'hC9, outs);
    error_ack <= 1'b1;
    cyc(1);
    error_ack <= 1'b0;
    cyc(4);
    chk("error cleared", 8'hE8, outs);
  endtask

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 500 clocks
  initial begin
    repeat (4000) @(posedge clock);
    fails++;
    stop_test();
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    cmd_a = 1'b0;
    cmd_b = 1'b0;
    test_start = 1'b0;
    error_ack = 1'b0;
    fails = 0;
    tests_run = 0;
    // Twenty-one full clock periods in reset
    cyc(21);
    chk("reset outputs", 8'h00, outs);
    rst <= 1'b0;
    t_release();
    t_test_pulse();
    t_request();
    t_staggered();
    t_discrepancy();
    stop_test();
  end
endmodule // toff_monitor_bench
